// [core/bsfo_top.sv]
// block-transfer source fetch and ordering engine with APB registers
`timescale 1ns/1ps
`default_nettype none
module bsfo_top
    import bsfo_pkg::*;
#(
    parameter int AW = BSFO_ADDR_W,
    parameter logic [15:0] WIN_BASE = WIN_BASE_RESET
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic hw_valid,
    input wire logic [31:0] hw_addr,
    input wire logic [63:0] hw_data,
    output logic hw_ready,
    input wire logic hr_valid,
    input wire logic [31:0] hr_addr,
    output logic hr_ack,
    output logic [63:0] hr_data,
    output logic out_valid,
    output logic [AW-1:0] out_src_addr,
    output logic [AW-1:0] out_dst_addr,
    output logic [7:0] out_byte,
    output logic out_host,
    output logic out_mono,
    output logic busy
);
    bsfo_src_if sif ();
    bsfo_state_t st;
    logic [31:0] pitch_reg;
    logic [31:0] ctrl_reg;
    logic [31:0] run_ctrl;
    logic [AW-1:0] src_reg;
    logic [AW-1:0] dst_reg;
    logic [31:0] extent_reg;
    logic access;
    logic wr;
    logic start_ok;
    logic load;
    logic run_host;
    logic go;
    logic s_last;
    logic d_last;
    logic [AW-1:0] s_addr;
    logic [AW-1:0] d_addr;
    logic in_win_wr;
    logic in_win_rd;

    // one wait state: pready rises in the second access cycle
    assign access = psel && penable && !pready;
    assign wr = access && pwrite;
    assign start_ok = wr && paddr == OFS_EXTENT && st == ST_IDLE &&
        pwdata[15:0] != 16'h0000 && pwdata[31:16] != 16'h0000;
    assign run_host = run_ctrl[CTRL_HOST];
    assign go = st == ST_RUN && (!run_host || sif.byte_valid);
    assign in_win_wr = hw_addr[31:16] == WIN_BASE;
    assign in_win_rd = hr_addr[31:16] == WIN_BASE;
    assign hw_ready = sif.room;

    assign sif.qw_valid = hw_valid && in_win_wr;
    assign sif.qw_data = hw_data;
    assign sif.start = load;
    assign sif.flush = st == ST_END;
    assign sif.skip = src_reg[2:0];
    assign sif.take = go && run_host;

    bsfo_unpack u_unpack (
        .mclk(mclk),
        .rst_b(rst_b),
        .sif(sif)
    );

    bsfo_walk u_src (
        .mclk(mclk),
        .rst_b(rst_b),
        .load(load),
        .adv(go),
        .base(src_reg),
        .len(extent_reg[15:0]),
        .lines(extent_reg[31:16]),
        .pitch(pitch_reg[15:0]),
        .xdec(run_ctrl[CTRL_XDEC]),
        .ydec(run_ctrl[CTRL_YDEC]),
        .addr(s_addr),
        .last(s_last)
    );

    bsfo_walk u_dst (
        .mclk(mclk),
        .rst_b(rst_b),
        .load(load),
        .adv(go),
        .base(dst_reg),
        .len(extent_reg[15:0]),
        .lines(extent_reg[31:16]),
        .pitch(pitch_reg[31:16]),
        .xdec(run_ctrl[CTRL_XDEC]),
        .ydec(run_ctrl[CTRL_YDEC]),
        .addr(d_addr),
        .last(d_last)
    );

    // register writes
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pitch_reg <= PITCH_RESET;
            ctrl_reg <= CTRL_RESET;
            src_reg <= '0;
            dst_reg <= '0;
            extent_reg <= EXTENT_RESET;
        end else if (wr) begin
            unique case (paddr)
                OFS_PITCH: pitch_reg <= pwdata;
                OFS_CTRL: ctrl_reg <= pwdata & CTRL_MASK;
                OFS_SRC: src_reg <= pwdata[AW-1:0];
                OFS_DST: dst_reg <= pwdata[AW-1:0];
                OFS_EXTENT: if (start_ok) extent_reg <= pwdata;
                default: ;
            endcase
        end
    end

    // bus answer
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else begin
            pready <= access;
            pslverr <= 1'b0;
            prdata <= 32'h0;
            if (access) begin
                unique case (paddr)
                    OFS_PITCH: prdata <= pitch_reg;
                    OFS_CTRL: prdata <= ctrl_reg;
                    OFS_SRC: prdata <= 32'(src_reg);
                    OFS_DST: prdata <= 32'(dst_reg);
                    OFS_EXTENT: prdata <= extent_reg;
                    OFS_STATUS: begin
                        prdata[STAT_BUSY] <= st != ST_IDLE;
                        prdata[STAT_WAIT] <= st == ST_RUN && run_host && !sif.byte_valid;
                        if (pwrite) pslverr <= 1'b1;
                    end
                    default: pslverr <= 1'b1;
                endcase
            end
        end
    end

    // control is frozen for the run so a rewrite cannot change direction midway
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            load <= 1'b0;
            run_ctrl <= CTRL_RESET;
        end else begin
            load <= start_ok;
            if (load) run_ctrl <= ctrl_reg;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            st <= ST_IDLE;
        end else begin
            unique case (st)
                ST_IDLE: if (load) st <= ST_RUN;
                ST_RUN: if (go && s_last) st <= ST_END;
                ST_END: st <= ST_IDLE;
            endcase
        end
    end

    // per-byte request toward the frame buffer side
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            out_valid <= 1'b0;
            out_src_addr <= '0;
            out_dst_addr <= '0;
            out_byte <= 8'h00;
            out_host <= 1'b0;
            out_mono <= 1'b0;
            busy <= 1'b0;
        end else begin
            out_valid <= go;
            busy <= (st != ST_IDLE && st != ST_END) || load;
            out_host <= run_host;
            out_mono <= run_ctrl[CTRL_MONO];
            if (go) begin
                out_src_addr <= s_addr;
                out_dst_addr <= d_addr;
                out_byte <= run_host ? sif.byte_data : 8'h00;
            end
        end
    end

    // window reads are answered but carry nothing back
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            hr_ack <= 1'b0;
            hr_data <= 64'h0;
        end else begin
            hr_ack <= hr_valid && in_win_rd;
            hr_data <= 64'h0;
        end
    end

    sequence s_final;
        st == ST_RUN && go && s_last;
    endsequence
    sequence s_wind_down;
        st == ST_END ##1 st == ST_IDLE;
    endsequence

    a_run_ends: assert property (@(posedge mclk) disable iff (!rst_b)
        s_final |=> s_wind_down)
        else $error("run did not end after the last byte");
    a_start_run: assert property (@(posedge mclk) disable iff (!rst_b)
        start_ok |=> load ##1 st == ST_RUN && busy)
        else $error("start did not begin a run");
    a_host_stall: assert property (@(posedge mclk) disable iff (!rst_b)
        st == ST_RUN && run_host && !sif.byte_valid |=> !out_valid)
        else $error("host source emitted without data");
    a_read_empty: assert property (@(posedge mclk) disable iff (!rst_b)
        hr_valid && in_win_rd |=> hr_ack && hr_data == 64'h0)
        else $error("window read returned data");
    a_ends_agree: assert property (@(posedge mclk) disable iff (!rst_b)
        st == ST_RUN |-> s_last == d_last)
        else $error("source and destination walks out of step");

    // a host byte is only emitted while the holding slot has one
    sequence s_host_byte;
        st == ST_RUN && run_host && sif.byte_valid;
    endsequence
    // a start request that must leave the extent and the engine untouched
    sequence s_refused_start;
        wr && paddr == OFS_EXTENT &&
            (st != ST_IDLE || pwdata[15:0] == 16'h0000 || pwdata[31:16] == 16'h0000);
    endsequence

    a_ctrl_masked: assert property (@(posedge mclk) disable iff (!rst_b)
        (ctrl_reg & ~CTRL_MASK) == 32'h0000_0000)
        else $error("control register holds an unused bit");

    a_ctrl_frozen: assert property (@(posedge mclk) disable iff (!rst_b)
        !load
        |=> $stable(run_ctrl))
        else $error("run control changed during a run");

    a_refuse_start: assert property (@(posedge mclk) disable iff (!rst_b)
        s_refused_start
        |=> $stable(extent_reg) && !load)
        else $error("refused start changed the extent or began a run");

    a_idle_quiet: assert property (@(posedge mclk) disable iff (!rst_b)
        st == ST_IDLE && !load
        |=> !busy && !out_valid)
        else $error("idle engine shows activity");

    a_busy_run: assert property (@(posedge mclk) disable iff (!rst_b)
        st == ST_RUN
        |-> busy)
        else $error("busy low while running");

    a_end_idle: assert property (@(posedge mclk) disable iff (!rst_b)
        st == ST_END
        |=> st == ST_IDLE && !busy)
        else $error("engine did not return to idle");

    a_one_hot: assert property (@(posedge mclk) disable iff (!rst_b)
        $onehot(st))
        else $error("state code is not one-hot");

    a_fb_no_stall: assert property (@(posedge mclk) disable iff (!rst_b)
        st == ST_RUN && !run_host
        |-> go)
        else $error("frame buffer source stalled");

    a_fb_byte_zero: assert property (@(posedge mclk) disable iff (!rst_b)
        go && !run_host
        |=> out_byte == 8'h00)
        else $error("frame buffer run carried a host byte");

    a_host_out: assert property (@(posedge mclk) disable iff (!rst_b)
        s_host_byte
        |=> out_valid && out_byte == $past(sif.byte_data))
        else $error("host byte not passed on in order");

    a_out_follows: assert property (@(posedge mclk) disable iff (!rst_b)
        go
        |=> out_valid && out_src_addr == $past(s_addr) && out_dst_addr == $past(d_addr))
        else $error("byte request does not carry the walk address");

    a_flags_follow: assert property (@(posedge mclk) disable iff (!rst_b)
        1'b1
        |=> out_host == $past(run_host) && out_mono == $past(run_ctrl[CTRL_MONO]))
        else $error("source kind flags do not follow run control");

    a_win_filter: assert property (@(posedge mclk) disable iff (!rst_b)
        hw_valid && !in_win_wr
        |-> !sif.qw_valid)
        else $error("write outside the window reached the slot");

    a_read_idle: assert property (@(posedge mclk) disable iff (!rst_b)
        !(hr_valid && in_win_rd)
        |=> !hr_ack)
        else $error("window read answered without a request");

    a_flush_frees: assert property (@(posedge mclk) disable iff (!rst_b)
        st == ST_END
        |=> hw_ready && !sif.byte_valid)
        else $error("leftover bytes kept after the run");

    a_wait_flag: assert property (@(posedge mclk) disable iff (!rst_b)
        access && !pwrite && paddr == OFS_STATUS && st == ST_RUN && run_host && !sif.byte_valid
        |=> pready && prdata[STAT_WAIT])
        else $error("status does not report waiting for host data");
endmodule
`default_nettype wire

// [core/bsfo_pkg.sv]
// constants, types and helpers of the block-transfer source fetch and ordering engine
package bsfo_pkg;
    localparam int BSFO_ADDR_W = 24;
    localparam logic [7:0] OFS_PITCH = 8'h00;
    localparam logic [7:0] OFS_CTRL = 8'h04;
    localparam logic [7:0] OFS_SRC = 8'h08;
    localparam logic [7:0] OFS_DST = 8'h0c;
    localparam logic [7:0] OFS_EXTENT = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam int CTRL_XDEC = 8;
    localparam int CTRL_YDEC = 9;
    localparam int CTRL_HOST = 10;
    localparam int CTRL_MONO = 12;
    localparam logic [31:0] CTRL_MASK = 32'h0000_1700;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] PITCH_RESET = 32'h0000_0000;
    localparam logic [31:0] EXTENT_RESET = 32'h0000_0000;
    localparam int STAT_BUSY = 0;
    localparam int STAT_WAIT = 1;
    localparam logic [15:0] WIN_BASE_RESET = 16'h00a0;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_RUN = 3'b010,
        ST_END = 3'b100
    } bsfo_state_t;

    function automatic logic [BSFO_ADDR_W-1:0] bsfo_step(
        input logic [BSFO_ADDR_W-1:0] a,
        input logic dec,
        input logic [15:0] d
    );
        logic [BSFO_ADDR_W-1:0] dd;
        dd = BSFO_ADDR_W'(d);
        bsfo_step = dec ? a - dd : a + dd;
    endfunction
endpackage

// [core/bsfo_src_if.sv]
// carrier between the engine and the host source-port unpacker
`timescale 1ns/1ps
`default_nettype none
interface bsfo_src_if;
    logic qw_valid;
    logic [63:0] qw_data;
    logic room;
    logic start;
    logic flush;
    logic [2:0] skip;
    logic [7:0] byte_data;
    logic byte_valid;
    logic take;
    modport port (input qw_valid, qw_data, start, flush, skip, take,
        output room, byte_data, byte_valid);
    modport eng (output qw_valid, qw_data, start, flush, skip, take,
        input room, byte_data, byte_valid);
endinterface
`default_nettype wire

// [core/bsfo_walk.sv]
// rectangle address walker: one byte step per advance within a line, a pitch step from the line start at each line end
`timescale 1ns/1ps
`default_nettype none
module bsfo_walk
    import bsfo_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic load,
    input wire logic adv,
    input wire logic [BSFO_ADDR_W-1:0] base,
    input wire logic [15:0] len,
    input wire logic [15:0] lines,
    input wire logic [15:0] pitch,
    input wire logic xdec,
    input wire logic ydec,
    output logic [BSFO_ADDR_W-1:0] addr,
    output logic last
);
    logic [BSFO_ADDR_W-1:0] line_start;
    logic [15:0] col;
    logic [15:0] row;
    logic eol;
    logic eob;
    assign eol = (col == len - 16'h0001);
    assign eob = (row == lines - 16'h0001);
    assign last = eol && eob;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            addr <= '0;
            line_start <= '0;
            col <= 16'h0000;
            row <= 16'h0000;
        end else if (load) begin
            addr <= base;
            line_start <= base;
            col <= 16'h0000;
            row <= 16'h0000;
        end else if (adv) begin
            if (eol) begin
                col <= 16'h0000;
                row <= row + 16'h0001;
                line_start <= bsfo_step(line_start, ydec, pitch);
                addr <= bsfo_step(line_start, ydec, pitch);
            end else begin
                col <= col + 16'h0001;
                addr <= bsfo_step(addr, xdec, 16'h0001);
            end
        end
    end

    a_load_base: assert property (@(posedge mclk) disable iff (!rst_b)
        load |=> addr == $past(base) && col == 16'h0000 && row == 16'h0000)
        else $error("walker did not load the corner address");
    a_pixel_step: assert property (@(posedge mclk) disable iff (!rst_b)
        adv && !load && !eol |=>
        addr == ($past(xdec) ? $past(addr) - 1'b1 : $past(addr) + 1'b1))
        else $error("pixel step has wrong direction");
    a_line_step: assert property (@(posedge mclk) disable iff (!rst_b)
        adv && !load && eol |=> col == 16'h0000 &&
        addr == bsfo_step($past(line_start), $past(ydec), $past(pitch)))
        else $error("line step does not follow pitch");
endmodule
`default_nettype wire

// [core/bsfo_unpack.sv]
// host source port: one quadword holding slot, unpacked byte by byte
`timescale 1ns/1ps
`default_nettype none
module bsfo_unpack (
    input wire logic mclk,
    input wire logic rst_b,
    bsfo_src_if.port sif
);
    logic [63:0] qw;
    logic full;
    logic first;
    logic [2:0] idx;
    logic accept;
    assign accept = sif.qw_valid && sif.room;
    assign sif.byte_valid = full;
    assign sif.byte_data = qw[{idx, 3'b000} +: 8];

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            qw <= 64'h0;
            full <= 1'b0;
            sif.room <= 1'b1;
        end else if (sif.flush) begin
            full <= 1'b0; // tail padding of the aligned stream is dropped
            sif.room <= 1'b1;
        end else if (accept) begin
            qw <= sif.qw_data;
            full <= 1'b1;
            sif.room <= 1'b0;
        end else if (sif.take && full && idx == 3'h7) begin
            full <= 1'b0;
            sif.room <= 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            idx <= 3'h0;
            first <= 1'b0;
        end else if (sif.start) begin
            idx <= sif.skip;
            first <= 1'b1;
        end else if (accept) begin
            idx <= first ? sif.skip : 3'h0;
        end else if (sif.take && full) begin
            idx <= idx + 3'h1;
            first <= 1'b0;
        end
    end

    a_skip_first: assert property (@(posedge mclk) disable iff (!rst_b)
        sif.start && !sif.flush |=> idx == $past(sif.skip) && first)
        else $error("skip count not applied to first quadword");
    a_byte_order: assert property (@(posedge mclk) disable iff (!rst_b)
        sif.take && full && idx != 3'h7 && !sif.start && !sif.flush |=>
        full && idx == $past(idx) + 3'h1)
        else $error("bytes not taken in order");
    a_accept_hold: assert property (@(posedge mclk) disable iff (!rst_b)
        accept && !sif.flush |=> full && !sif.room && qw == $past(sif.qw_data))
        else $error("window write not captured");
endmodule
`default_nettype wire

// [verification/bsfo_host.sv]
// host model: source quadwords into the data window, reads of the window
`timescale 1ns/1ps
`default_nettype none
module bsfo_host
    import bsfo_pkg::*;
#(
    parameter logic [15:0] WIN_BASE = WIN_BASE_RESET
) (
    input wire logic mclk,
    input wire logic hw_ready,
    input wire logic hr_ack,
    input wire logic [63:0] hr_data,
    output logic hw_valid,
    output logic [31:0] hw_addr,
    output logic [63:0] hw_data,
    output logic hr_valid,
    output logic [31:0] hr_addr
);
    initial begin
        hw_valid = 1'b0;
        hw_addr = 32'h0000_0000;
        hw_data = 64'h0;
        hr_valid = 1'b0;
        hr_addr = 32'h0000_0000;
    end

    // whole quadwords at aligned addresses only
    task automatic send(input logic [15:0] ofs, input logic [63:0] d, output logic ok);
        int n;
        @(posedge mclk);
        hw_valid <= 1'b1;
        hw_addr <= {WIN_BASE, ofs & 16'hfff8};
        hw_data <= d;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (hw_ready !== 1'b1 && n < 200);
        ok = hw_ready === 1'b1;
        hw_valid <= 1'b0;
        // released lines must not keep the old value
        hw_addr <= ~{WIN_BASE, ofs};
        hw_data <= ~d;
    endtask

    task automatic peek(input logic [15:0] ofs, output logic [63:0] d, output logic ok);
        int n;
        @(posedge mclk);
        hr_valid <= 1'b1;
        hr_addr <= {WIN_BASE, ofs};
        @(posedge mclk);
        hr_valid <= 1'b0;
        hr_addr <= ~{WIN_BASE, ofs};
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (hr_ack !== 1'b1 && n < 20);
        ok = hr_ack === 1'b1;
        d = hr_data;
    endtask
endmodule
`default_nettype wire

// [verification/blit_source_fetch_and_ordering_tb_top.sv]
// self-checking bench: registers, corner walks, host source stream
`timescale 1ns/1ps
`default_nettype none
module blit_source_fetch_and_ordering_tb_top
    import bsfo_pkg::*;
;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, hw_addr, hr_addr;
    logic pready, pslverr, hw_valid, hw_ready, hr_valid, hr_ack;
    logic out_valid, out_host, out_mono, busy, ok, e;
    logic [63:0] hw_data, hr_data, r64;
    logic [23:0] out_src_addr, out_dst_addr;
    logic [7:0] out_byte;
    logic [31:0] r;
    logic [23:0] qs[$];
    logic [23:0] qd[$];
    logic [7:0] qb[$];
    int failures = 0;
    int checks = 0;

    always #20 mclk = ~mclk;

    bsfo_top i_dut (.mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .hw_valid(hw_valid), .hw_addr(hw_addr), .hw_data(hw_data),
        .hw_ready(hw_ready), .hr_valid(hr_valid), .hr_addr(hr_addr), .hr_ack(hr_ack),
        .hr_data(hr_data), .out_valid(out_valid), .out_src_addr(out_src_addr),
        .out_dst_addr(out_dst_addr), .out_byte(out_byte), .out_host(out_host),
        .out_mono(out_mono), .busy(busy));

    bsfo_host i_host (.mclk(mclk), .hw_ready(hw_ready), .hr_ack(hr_ack), .hr_data(hr_data),
        .hw_valid(hw_valid), .hw_addr(hw_addr), .hw_data(hw_data), .hr_valid(hr_valid),
        .hr_addr(hr_addr));

    task automatic print_verdict();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic hang();
        failures++;
        $display("[FAIL] %0t wait ran out", $time);
        print_verdict();
    endtask

    task automatic chk(input logic [63:0] s, input logic [63:0] x);
        checks++;
        if (s !== x) begin
            failures++;
            $display("[FAIL] %0t got %h want %h", $time, s, x);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) hang();
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0000_0000);
        chk(r, x);
        chk(e, 1'b0);
    endtask

    // gathers n output pulses, then expects the engine to go quiet
    task automatic collect(input int n, input logic h, input logic m);
        int t;
        qs.delete();
        qd.delete();
        qb.delete();
        t = 0;
        while (qs.size() < n && t < 500) begin
            @(posedge mclk);
            t++;
            if (out_valid === 1'b1) begin
                qs.push_back(out_src_addr);
                qd.push_back(out_dst_addr);
                qb.push_back(out_byte);
                chk(out_host, h);
                chk(out_mono, m);
            end
        end
        if (qs.size() < n) hang();
        repeat (3) begin
            @(posedge mclk);
            chk(out_valid, 1'b0);
        end
        chk(busy, 1'b0);
    endtask

    function automatic logic [23:0] corner(input logic [23:0] b, input int pt, input int len,
                                           input logic xd, input logic yd, input int k);
        int l;
        int p;
        l = k / len;
        p = k % len;
        corner = b + 24'(yd ? -l * pt : l * pt) + 24'(xd ? -p : p);
    endfunction

    initial begin
        int sp;
        logic xd;
        logic yd;
        repeat (20) @(posedge mclk);
        rst_b <= 1'b1;
        rd(OFS_CTRL, CTRL_RESET);
        rd(OFS_PITCH, PITCH_RESET);
        rd(OFS_STATUS, 32'h0000_0000);
        apb(1'b1, OFS_CTRL, 32'hffff_ffff);
        rd(OFS_CTRL, CTRL_MASK);
        apb(1'b0, 8'h20, 32'h0000_0000);
        chk(e, 1'b1);
        apb(1'b1, OFS_STATUS, 32'h0000_0003);
        chk(e, 1'b1);
        apb(1'b1, OFS_CTRL, 32'h0000_0000);
        apb(1'b1, OFS_EXTENT, 32'h0002_0000);
        rd(OFS_STATUS, 32'h0000_0000);
        rd(OFS_EXTENT, EXTENT_RESET);
        for (int c = 0; c < 4; c++) begin
            xd = c[0];
            yd = c[1];
            // first pass contiguous: pitch equals line length
            sp = (c == 0) ? 3 : 256;
            apb(1'b1, OFS_CTRL, {19'h0, yd, 2'b00, yd, xd, 8'h00});
            apb(1'b1, OFS_PITCH, {16'h0200, 16'(sp)});
            apb(1'b1, OFS_SRC, 32'h0002_8100);
            apb(1'b1, OFS_DST, 32'h0004_0000);
            apb(1'b1, OFS_EXTENT, 32'h0002_0003);
            collect(6, 1'b0, yd);
            for (int k = 0; k < 6; k++) begin
                chk(qs[k], corner(24'h028100, sp, 3, xd, yd, k));
                chk(qd[k], corner(24'h040000, 512, 3, xd, yd, k));
            end
        end
        rd(OFS_SRC, 32'h0002_8100);
        rd(OFS_EXTENT, 32'h0002_0003);
        apb(1'b1, OFS_CTRL, 32'h0000_0400);
        apb(1'b1, OFS_SRC, 32'h0000_0003);
        apb(1'b1, OFS_DST, 32'h0000_0800);
        apb(1'b1, OFS_EXTENT, 32'h0002_0006);
        fork
            collect(12, 1'b1, 1'b0);
            begin
                rd(OFS_STATUS, 32'h0000_0003);
                i_host.send(16'h1230, 64'h1716_1514_1312_1110, ok);
                chk(ok, 1'b1);
                i_host.send(16'h0008, 64'h2726_2524_2322_2120, ok);
                chk(ok, 1'b1);
            end
        join
        for (int k = 0; k < 12; k++) begin
            chk(qb[k], k < 5 ? 8'h13 + 8'(k) : 8'h1b + 8'(k));
            chk(qd[k], corner(24'h000800, 512, 6, 1'b0, 1'b0, k));
        end
        // leftover bytes of the last quadword must be dropped
        chk(hw_ready, 1'b1);
        i_host.peek(16'h1230, r64, ok);
        chk(ok, 1'b1);
        chk(r64, 64'h0);
        // overlapping move down and right, started bottom-right inside the overlap
        apb(1'b1, OFS_CTRL, 32'h0000_0300);
        apb(1'b1, OFS_PITCH, 32'h0100_0100);
        apb(1'b1, OFS_SRC, 32'h0002_8203);
        apb(1'b1, OFS_DST, 32'h0002_8304);
        apb(1'b1, OFS_EXTENT, 32'h0002_0004);
        collect(8, 1'b0, 1'b0);
        for (int k = 0; k < 8; k++) begin
            chk(qs[k], corner(24'h028203, 256, 4, 1'b1, 1'b1, k));
            for (int j = k + 1; j < 8; j++) begin
                chk(qd[k] == qs[j], 1'b0);
            end
        end
        print_verdict();
    end
endmodule
`default_nettype wire
